// *** verilog/dctz_defines.svh ***
// Offsets, field positions, opcodes and hint codes of the touch/zero unit
`ifndef DCTZ_DEFINES_SVH
`define DCTZ_DEFINES_SVH
// APB register byte offsets
`define DCTZ_OFF_INSN     8'h00
`define DCTZ_OFF_CTRL     8'h04
`define DCTZ_OFF_ATTR     8'h08
`define DCTZ_OFF_BASE_LO  8'h0c
`define DCTZ_OFF_BASE_HI  8'h10
`define DCTZ_OFF_INDEX_LO 8'h14
`define DCTZ_OFF_INDEX_HI 8'h18
`define DCTZ_OFF_STATUS   8'h1c
`define DCTZ_OFF_EA_LO    8'h20
`define DCTZ_OFF_EA_HI    8'h24
`define DCTZ_OFF_STREAM   8'h28
// Control bits
`define DCTZ_CTRL_GO      0
`define DCTZ_CTRL_LINE    1
// Attribute bits from translation
`define DCTZ_ATTR_DSTORE  0
`define DCTZ_ATTR_LOAD_OK 1
`define DCTZ_ATTR_STOR_OK 2
`define DCTZ_ATTR_CINH    3
`define DCTZ_ATTR_GUARD   4
// Instruction word fields, little-endian bit indices
`define DCTZ_OPCD_HI      31
`define DCTZ_OPCD_LO      26
`define DCTZ_HINT_HI      25
`define DCTZ_HINT_LO      21
`define DCTZ_BASE_HI      20
`define DCTZ_BASE_LO      16
`define DCTZ_INDEX_HI     15
`define DCTZ_INDEX_LO     11
`define DCTZ_XO_HI        10
`define DCTZ_XO_LO        1
`define DCTZ_FORM_BIT     0
// Opcodes
`define DCTZ_OPCD_X       6'h1f
`define DCTZ_XO_TOUCH_ST  10'h0f6
`define DCTZ_XO_ZERO      10'h3f6
// Hint codes
`define DCTZ_HINT_BYTE    5'h00
`define DCTZ_HINT_FWD     5'h01
`define DCTZ_HINT_BWD     5'h03
`define DCTZ_HINT_DESC    5'h08
`define DCTZ_HINT_CTRL    5'h0a
// Stream control word fields
`define DCTZ_SCW_GO       31
`define DCTZ_SCW_STOP_HI  30
`define DCTZ_SCW_STOP_LO  29
`define DCTZ_SCW_LEN_HI   16
`define DCTZ_SCW_LEN_LO   7
`define DCTZ_SCW_ID_HI    3
`define DCTZ_SCW_ID_LO    0
`define DCTZ_STOP_ONE     2'h2
`define DCTZ_STOP_ALL     2'h3
`endif

// *** verilog/dctz_pkg.sv ***
// Types shared by the touch/zero unit
package dctz_pkg;
  // Command issued to the data cache
  typedef enum logic [2:0] {
    DCTZ_CMD_NONE,
    DCTZ_CMD_TOUCH,
    DCTZ_CMD_PROBE,
    DCTZ_CMD_ZERO_CLR,
    DCTZ_CMD_ZERO_ALLOC
  } dctz_cmd_t;
  // Engine states
  typedef enum logic [1:0] {
    DCTZ_IDLE,
    DCTZ_TOUCH,
    DCTZ_PROBE,
    DCTZ_ZERO
  } dctz_state_t;
endpackage

// *** verilog/dctz_unit.sv ***
// Touch-for-store and block/line zero engine with APB registers
// Functional notes
// - Touch address: base plus index, base zero-able
// - Touch prefetches block, never raises exception
// - Touch in direct-store segment does nothing
// - Touch checked as load; denied means nothing
// - Touch leaves CR0 and XER untouched
// - Hint ignored when inhibited or guarded
// - Two-operand touch form means hint zero
// - Hint 0000: store to addressed byte soon
// - Hint 0001: forward store stream of blocks
// - Hint 0011: backward store stream of blocks
// - Hint 1000: address is stream descriptor
// - Hint 1010: address is stream control word
// - Zero address: base plus index, base zero-able
// - Zero present block or line entirely
// - Absent: allocate without memory read, zero
// - Line form writes address back to base
// - Zero forms checked as stores
// - Zero leaves XER; bit 31 set invalid
// - Control word bits 47-56 give stream length
// - Stop 10 stops one stream, 11 all
`timescale 1ns/100ps
`include "dctz_defines.svh"
module dctz_unit #(
  parameter int ADDR_W      = 64,
  parameter int BLOCK_BYTES = 32,
  parameter int LINE_BYTES  = 64
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   cache_req,
  output dctz_pkg::dctz_cmd_t    cache_cmd,
  output logic      [ADDR_W-1:0] cache_addr,
  output logic      [4:0]        cache_hint,
  input  wire logic              cache_ack,
  input  wire logic              cache_hit,
  output logic                   stream_stop_one,
  output logic                   stream_stop_all,
  output logic      [3:0]        stream_id,
  output logic                   base_wb_valid,
  output logic      [4:0]        base_wb_idx,
  output logic      [ADDR_W-1:0] base_wb_data
);
  // Elaboration checks: the register map splits every address into two
  // 32-bit words, and the masks in align() need power-of-two granules
  if (ADDR_W != 64) begin : g_chk_addr
    $error("dctz_unit: ADDR_W must be 64");
  end
  if (BLOCK_BYTES < 4 || (BLOCK_BYTES & (BLOCK_BYTES - 1)) != 0) begin : g_chk_block
    $error("dctz_unit: BLOCK_BYTES must be a power of two");
  end
  if (LINE_BYTES < 4 || (LINE_BYTES & (LINE_BYTES - 1)) != 0) begin : g_chk_line
    $error("dctz_unit: LINE_BYTES must be a power of two");
  end
  // A line must hold whole blocks, else line addresses lose block alignment
  if (LINE_BYTES < BLOCK_BYTES) begin : g_chk_ratio
    $error("dctz_unit: LINE_BYTES must not be below BLOCK_BYTES");
  end

  // Effective address; a zero base field means zero, not GPR0
  function automatic logic [ADDR_W-1:0] calc_ea(input logic [4:0] base_fld,
                                                input logic [ADDR_W-1:0] base_v,
                                                input logic [ADDR_W-1:0] idx_v);
    calc_ea = (base_fld == 5'h00) ? idx_v : base_v + idx_v;
  endfunction

  // Clear the offset bits below a power-of-two granule
  function automatic logic [ADDR_W-1:0] align(input logic [ADDR_W-1:0] a,
                                              input int bytes);
    logic [ADDR_W-1:0] m;
    m = ADDR_W'(bytes - 1);
    align = a & ~m;
  endfunction

  // Software-visible registers
  logic [31:0]       insn_q;      // Instruction word under execution
  logic              line_q;      // Line-granule zero form selected
  logic [4:0]        attr_q;      // Translation attributes for the access
  logic [ADDR_W-1:0] base_q;      // Base register contents
  logic [ADDR_W-1:0] index_q;     // Index register contents
  logic              go_q;        // One-cycle start pulse
  // Engine state and results
  dctz_pkg::dctz_state_t state_q; // Engine state
  logic              done_q;      // Last operation finished
  logic              noop_q;      // Last operation did nothing
  logic              invalid_q;   // Unknown or invalid form
  logic              deny_q;      // Protection refused the access
  logic              hit_q;       // Zero target was already cached
  logic [ADDR_W-1:0] ea_q;        // Last effective address
  logic [9:0]        len_q;       // Stream length from control word
  logic              sgo_q;       // Stream start bit from control word
  logic              sdesc_q;     // Descriptor recorded for a stream

  // Decoded fields of the held instruction, effective address, hint and APB strobes
  logic [5:0]        opcd;
  logic [9:0]        xo;
  logic [4:0]        hint_fld;
  logic [4:0]        base_fld;
  logic [4:0]        idx_fld;
  logic              is_touch;
  logic              is_zero;
  logic [ADDR_W-1:0] ea;
  logic [4:0]        hint_eff;
  logic              apb_acc;
  logic              apb_wr;

  assign opcd     = insn_q[`DCTZ_OPCD_HI:`DCTZ_OPCD_LO];
  assign xo       = insn_q[`DCTZ_XO_HI:`DCTZ_XO_LO];
  assign hint_fld = insn_q[`DCTZ_HINT_HI:`DCTZ_HINT_LO];
  assign base_fld = insn_q[`DCTZ_BASE_HI:`DCTZ_BASE_LO];
  assign idx_fld  = insn_q[`DCTZ_INDEX_HI:`DCTZ_INDEX_LO];
  // Only the two operations this unit owns are accepted
  assign is_touch = (opcd == `DCTZ_OPCD_X) && (xo == `DCTZ_XO_TOUCH_ST);
  assign is_zero  = (opcd == `DCTZ_OPCD_X) && (xo == `DCTZ_XO_ZERO);
  // Same adder serves both operations
  assign ea       = calc_ea(base_fld, base_q, index_q);
  // Inhibited or guarded space drops the hint to a plain touch
  assign hint_eff = (attr_q[`DCTZ_ATTR_CINH] || attr_q[`DCTZ_ATTR_GUARD])
                    ? `DCTZ_HINT_BYTE : hint_fld;
  // Write lands only on the edge where pready is seen high
  assign apb_acc  = psel && penable && pready;
  assign apb_wr   = apb_acc && pwrite;

  // APB response: one wait state, pready registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && penable && !pready) begin
        // Read mux; unmapped offsets answer with an error
        if (paddr == `DCTZ_OFF_INSN) begin
          prdata <= insn_q;
        end else if (paddr == `DCTZ_OFF_CTRL) begin
          prdata <= {30'h0, line_q, 1'b0};
        end else if (paddr == `DCTZ_OFF_ATTR) begin
          prdata <= {27'h0, attr_q};
        end else if (paddr == `DCTZ_OFF_BASE_LO) begin
          prdata <= base_q[31:0];
        end else if (paddr == `DCTZ_OFF_BASE_HI) begin
          prdata <= base_q[63:32];
        end else if (paddr == `DCTZ_OFF_INDEX_LO) begin
          prdata <= index_q[31:0];
        end else if (paddr == `DCTZ_OFF_INDEX_HI) begin
          prdata <= index_q[63:32];
        end else if (paddr == `DCTZ_OFF_STATUS) begin
          prdata <= {24'h0, base_wb_valid, hit_q, deny_q, invalid_q,
                     noop_q, done_q, 1'b0, state_q != dctz_pkg::DCTZ_IDLE};
        end else if (paddr == `DCTZ_OFF_EA_LO) begin
          prdata <= ea_q[31:0];
        end else if (paddr == `DCTZ_OFF_EA_HI) begin
          prdata <= ea_q[63:32];
        end else if (paddr == `DCTZ_OFF_STREAM) begin
          prdata <= {16'h0, sdesc_q, sgo_q, len_q, stream_id};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // Writable registers; operands are locked while busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      insn_q  <= 32'h0000_0000;
      line_q  <= 1'b0;
      attr_q  <= 5'h00;
      base_q  <= 64'h0;
      index_q <= 64'h0;
      go_q    <= 1'b0;
    end else begin
      go_q <= 1'b0;
      if (apb_wr && state_q == dctz_pkg::DCTZ_IDLE && !go_q) begin
        if (paddr == `DCTZ_OFF_INSN) begin
          insn_q <= pwdata;
        end else if (paddr == `DCTZ_OFF_CTRL) begin
          line_q <= pwdata[`DCTZ_CTRL_LINE];
          go_q   <= pwdata[`DCTZ_CTRL_GO];
        end else if (paddr == `DCTZ_OFF_ATTR) begin
          attr_q <= pwdata[4:0];
        end else if (paddr == `DCTZ_OFF_BASE_LO) begin
          base_q[31:0] <= pwdata;
        end else if (paddr == `DCTZ_OFF_BASE_HI) begin
          base_q[63:32] <= pwdata;
        end else if (paddr == `DCTZ_OFF_INDEX_LO) begin
          index_q[31:0] <= pwdata;
        end else if (paddr == `DCTZ_OFF_INDEX_HI) begin
          index_q[63:32] <= pwdata;
        end
      end
    end
  end

  // Operation engine: decode, check, drive the cache, report
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q         <= dctz_pkg::DCTZ_IDLE;
      cache_req       <= 1'b0;
      cache_cmd       <= dctz_pkg::DCTZ_CMD_NONE;
      cache_addr      <= 64'h0;
      cache_hint      <= 5'h00;
      done_q          <= 1'b0;
      noop_q          <= 1'b0;
      invalid_q       <= 1'b0;
      deny_q          <= 1'b0;
      hit_q           <= 1'b0;
      ea_q            <= 64'h0;
      len_q           <= 10'h000;
      sgo_q           <= 1'b0;
      sdesc_q         <= 1'b0;
      stream_stop_one <= 1'b0;
      stream_stop_all <= 1'b0;
      stream_id       <= 4'h0;
      base_wb_valid   <= 1'b0;
      base_wb_idx     <= 5'h00;
      base_wb_data    <= 64'h0;
    end else begin
      // Pulses last one cycle
      stream_stop_one <= 1'b0;
      stream_stop_all <= 1'b0;
      base_wb_valid   <= 1'b0;
      case (state_q)
        dctz_pkg::DCTZ_IDLE: begin
          if (go_q) begin
            // New operation clears the previous outcome
            done_q    <= 1'b0;
            noop_q    <= 1'b0;
            invalid_q <= 1'b0;
            deny_q    <= 1'b0;
            hit_q     <= 1'b0;
            ea_q      <= ea;
            if (is_touch) begin
              // Never faults: every refusal is a silent no-op
              if (attr_q[`DCTZ_ATTR_DSTORE]) begin
                noop_q <= 1'b1;
                done_q <= 1'b1;
              end else if (!attr_q[`DCTZ_ATTR_LOAD_OK]) begin
                noop_q <= 1'b1;
                done_q <= 1'b1;
              end else if (hint_eff == `DCTZ_HINT_DESC) begin
                // Address word carries stream attributes only
                sdesc_q   <= 1'b1;
                stream_id <= ea[`DCTZ_SCW_ID_HI:`DCTZ_SCW_ID_LO];
                done_q    <= 1'b1;
              end else if (hint_eff == `DCTZ_HINT_CTRL) begin
                stream_id <= ea[`DCTZ_SCW_ID_HI:`DCTZ_SCW_ID_LO];
                done_q    <= 1'b1;
                if (ea[`DCTZ_SCW_STOP_HI:`DCTZ_SCW_STOP_LO] == `DCTZ_STOP_ONE) begin
                  stream_stop_one <= 1'b1;
                end else if (ea[`DCTZ_SCW_STOP_HI:`DCTZ_SCW_STOP_LO] == `DCTZ_STOP_ALL) begin
                  stream_stop_all <= 1'b1;
                end else begin
                  // Length and go fields count only when no stop is asked; the ID is always taken
                  len_q <= ea[`DCTZ_SCW_LEN_HI:`DCTZ_SCW_LEN_LO];
                  sgo_q <= ea[`DCTZ_SCW_GO];
                end
              end else begin
                // Prefetch the block; hint tells cache byte or stream
                cache_req  <= 1'b1;
                cache_cmd  <= dctz_pkg::DCTZ_CMD_TOUCH;
                cache_addr <= align(ea, BLOCK_BYTES);
                // Reserved codes fall back to the single-byte hint
                cache_hint <= (hint_eff == `DCTZ_HINT_FWD || hint_eff == `DCTZ_HINT_BWD)
                              ? hint_eff : `DCTZ_HINT_BYTE;
                state_q    <= dctz_pkg::DCTZ_TOUCH;
              end
            end else if (is_zero && !insn_q[`DCTZ_FORM_BIT]) begin
              if (!attr_q[`DCTZ_ATTR_STOR_OK]) begin
                deny_q <= 1'b1;
                done_q <= 1'b1;
              end else begin
                // Ask the cache whether the target is resident
                cache_req  <= 1'b1;
                cache_cmd  <= dctz_pkg::DCTZ_CMD_PROBE;
                cache_addr <= line_q ? align(ea, LINE_BYTES) : align(ea, BLOCK_BYTES);
                cache_hint <= 5'h00;
                state_q    <= dctz_pkg::DCTZ_PROBE;
              end
            end else begin
              // Bit 31 set or foreign opcode: nothing reaches the cache
              invalid_q <= 1'b1;
              done_q    <= 1'b1;
            end
          end
        end
        dctz_pkg::DCTZ_TOUCH: begin
          if (cache_ack) begin
            cache_req <= 1'b0;
            cache_cmd <= dctz_pkg::DCTZ_CMD_NONE;
            done_q    <= 1'b1;
            state_q   <= dctz_pkg::DCTZ_IDLE;
          end
        end
        dctz_pkg::DCTZ_PROBE: begin
          if (cache_ack) begin
            // Hit clears in place; miss allocates with no fill read
            hit_q     <= cache_hit;
            cache_cmd <= cache_hit ? dctz_pkg::DCTZ_CMD_ZERO_CLR
                                   : dctz_pkg::DCTZ_CMD_ZERO_ALLOC;
            state_q   <= dctz_pkg::DCTZ_ZERO;
          end
        end
        dctz_pkg::DCTZ_ZERO: begin
          if (cache_ack) begin
            cache_req <= 1'b0;
            cache_cmd <= dctz_pkg::DCTZ_CMD_NONE;
            done_q    <= 1'b1;
            state_q   <= dctz_pkg::DCTZ_IDLE;
            // Line form updates the base register unless field is zero
            if (line_q && base_fld != 5'h00) begin
              base_wb_valid <= 1'b1;
              base_wb_idx   <= base_fld;
              base_wb_data  <= ea_q;
            end
          end
        end
        default: begin
          state_q <= dctz_pkg::DCTZ_IDLE;
        end
      endcase
    end
  end

  // Index field is decoded for completeness; index value comes via APB
  logic unused_idx;
  assign unused_idx = ^idx_fld;
endmodule

// *** sim/dctz_unit_asserts.sv ***
// Port checker for the touch/zero unit
`timescale 1ns/100ps
module dctz_unit_asserts #(
  parameter int ADDR_W      = 64,
  parameter int BLOCK_BYTES = 32
) (
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic                cache_req,
  input wire dctz_pkg::dctz_cmd_t cache_cmd,
  input wire logic [ADDR_W-1:0]   cache_addr,
  input wire logic [4:0]          cache_hint,
  input wire logic                cache_ack,
  input wire logic                cache_hit,
  input wire logic                stream_stop_one,
  input wire logic                stream_stop_all,
  input wire logic                base_wb_valid,
  input wire logic [4:0]          base_wb_idx
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Probe taken by the cache
  sequence s_probe_ack;
    cache_req && cache_cmd == dctz_pkg::DCTZ_CMD_PROBE && cache_ack;
  endsequence
  // Clear or allocate step requested
  sequence s_zero_step;
    cache_req && cache_cmd inside {dctz_pkg::DCTZ_CMD_ZERO_CLR, dctz_pkg::DCTZ_CMD_ZERO_ALLOC};
  endsequence
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("late apb answer");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready too long");
  a_data_idle: assert property (!pready |-> !pslverr && prdata == 32'h0)
    else $error("data outside answer");
  a_req_hold: assert property (cache_req && !cache_ack |=>
      cache_req && $stable(cache_cmd) && $stable(cache_addr))
    else $error("request moved before ack");
  a_probe_next: assert property (s_probe_ack |=> s_zero_step)
    else $error("no zero step after probe");
  a_hit_choice:
    assert property (s_probe_ack |=>
      (cache_cmd == dctz_pkg::DCTZ_CMD_ZERO_CLR) == $past(cache_hit))
    else $error("wrong zero step");
  a_touch_hint:
    assert property (cache_req && cache_cmd == dctz_pkg::DCTZ_CMD_TOUCH |->
      cache_hint inside {5'h00, 5'h01, 5'h03} && cache_addr % BLOCK_BYTES == 0)
    else $error("bad touch request");
  a_zero_align:
    assert property (cache_req && cache_cmd != dctz_pkg::DCTZ_CMD_TOUCH |->
      cache_addr % BLOCK_BYTES == 0 && cache_hint == 5'h00)
    else $error("bad zero request");
  a_stop_pulse:
    assert property (stream_stop_one || stream_stop_all |=>
      !stream_stop_one && !stream_stop_all)
    else $error("stop pulse too long");
  a_wb_cause:
    assert property (base_wb_valid |->
      ($past(cache_ack) && base_wb_idx != 5'h00) ##1 !base_wb_valid)
    else $error("bad base write back");
endmodule
bind dctz_unit dctz_unit_asserts #(.ADDR_W(ADDR_W), .BLOCK_BYTES(BLOCK_BYTES)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .cache_req(cache_req), .cache_cmd(cache_cmd),
  .cache_addr(cache_addr), .cache_hint(cache_hint), .cache_ack(cache_ack),
  .cache_hit(cache_hit), .stream_stop_one(stream_stop_one),
  .stream_stop_all(stream_stop_all), .base_wb_valid(base_wb_valid), .base_wb_idx(base_wb_idx)
);

// *** sim/dctz_cache_model.sv ***
// Data cache model answering the unit's commands
`timescale 1ns/100ps
module dctz_cache_model (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                cache_req,
  input  wire dctz_pkg::dctz_cmd_t cache_cmd,
  input  wire logic [63:0]         cache_addr,
  input  wire logic [4:0]          cache_hint,
  input  wire logic                hit_en,
  input  wire logic                slow,
  output logic                     cache_ack,
  output logic                     cache_hit,
  output dctz_pkg::dctz_cmd_t      last_cmd,
  output logic [63:0]              last_addr,
  output logic [4:0]               last_hint,
  output int                       n_ack
);
  logic [1:0] wait_q; // Cycles spent on this command
  // Ack at once or after three cycles; no memory read path, so a miss costs nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cache_ack <= 1'b0;
      cache_hit <= 1'b0;
      wait_q <= 2'h0;
      n_ack <= 0;
      last_cmd <= dctz_pkg::DCTZ_CMD_NONE;
      last_addr <= 64'h0;
      last_hint <= 5'h00;
    end else if (cache_ack) begin
      cache_ack <= 1'b0;
      cache_hit <= ~cache_hit;
      wait_q <= 2'h0;
    end else if (cache_req && wait_q >= (slow ? 2'h3 : 2'h0)) begin
      cache_ack <= 1'b1;
      cache_hit <= hit_en;
      last_cmd <= cache_cmd;
      last_addr <= cache_addr;
      last_hint <= cache_hint;
      n_ack <= n_ack + 1;
    end else begin
      // Hit line is garbage outside an ack
      cache_hit <= ~cache_hit;
      wait_q <= wait_q + 2'(cache_req);
    end
  end
endmodule

// *** sim/dctz_unit_bench.sv ***
// Self-checking bench for the touch/zero unit
`timescale 1ns/100ps
`include "dctz_defines.svh"
module dctz_unit_bench;
  localparam logic [63:0] BASE = 64'hffff_fff0; // Base value, carries into high word
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, cache_req;
  logic        cache_ack, cache_hit, stop_one, stop_all, wb_valid, hit_en, slow;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [63:0] cache_addr, wb_data_p, last_addr, wb_data;
  logic [4:0]  cache_hint, wb_idx_p, last_hint, wb_idx;
  logic [3:0]  stream_id;
  dctz_pkg::dctz_cmd_t cache_cmd, last_cmd;
  int          fails, num_checks, n_ack, n_wb, n_one, n_all;
  dctz_unit uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cache_req(cache_req), .cache_cmd(cache_cmd),
    .cache_addr(cache_addr), .cache_hint(cache_hint), .cache_ack(cache_ack),
    .cache_hit(cache_hit), .stream_stop_one(stop_one), .stream_stop_all(stop_all),
    .stream_id(stream_id), .base_wb_valid(wb_valid), .base_wb_idx(wb_idx_p),
    .base_wb_data(wb_data_p));
  dctz_cache_model u_cache (.pclk(pclk), .presetn(presetn), .cache_req(cache_req),
    .cache_cmd(cache_cmd), .cache_addr(cache_addr), .cache_hint(cache_hint),
    .hit_en(hit_en), .slow(slow), .cache_ack(cache_ack), .cache_hit(cache_hit),
    .last_cmd(last_cmd), .last_addr(last_addr), .last_hint(last_hint), .n_ack(n_ack));
  // Clock, 40 ns period
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Count one-cycle pulses
  always @(posedge pclk) begin
    if (wb_valid === 1'b1) begin
      n_wb++;
      wb_idx = wb_idx_p;
      wb_data = wb_data_p;
    end
    if (stop_one === 1'b1) n_one++;
    if (stop_all === 1'b1) n_all++;
  end
  task automatic cmp(input logic [63:0] g, input logic [63:0] x);
    num_checks++;
    if (g !== x) begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic end_sim();
    if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // One APB transfer, held until ready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask
  function automatic logic [31:0] mk(input logic [9:0] xo, input logic [4:0] h, b);
    return {`DCTZ_OPCD_X, h, b, 5'h02, xo, 1'b0};
  endfunction
  // Load operands, go, poll until done
  task automatic run(input logic [31:0] i, input logic ln, input logic [4:0] at,
                     input logic [63:0] x, output logic [31:0] st);
    wr(`DCTZ_OFF_INSN, i);
    wr(`DCTZ_OFF_ATTR, {27'h0, at});
    wr(`DCTZ_OFF_BASE_LO, BASE[31:0]);
    wr(`DCTZ_OFF_BASE_HI, BASE[63:32]);
    wr(`DCTZ_OFF_INDEX_LO, x[31:0]);
    wr(`DCTZ_OFF_INDEX_HI, x[63:32]);
    wr(`DCTZ_OFF_CTRL, {30'h0, ln, 1'b1});
    do rd(`DCTZ_OFF_STATUS, st); while (st[0] !== 1'b0 || st[2] !== 1'b1);
  endtask
  task automatic t_touch();
    logic [4:0]  th[6] = '{5'h01, 5'h03, 5'h00, 5'h02, 5'h01, 5'h03};
    logic [4:0]  at[6] = '{5'h02, 5'h02, 5'h02, 5'h02, 5'h0a, 5'h12};
    logic [4:0]  xh[6] = '{5'h01, 5'h03, 5'h00, 5'h00, 5'h00, 5'h00};
    logic [63:0] ea, x;
    logic [31:0] st, lo, hi;
    int          n0;
    for (int i = 0; i < 6; i++) begin
      x = 64'h30 + 64'h44 * i;
      ea = (i[0] ? BASE : 64'h0) + x;
      slow <= i[1];
      n0 = n_ack;
      run(mk(`DCTZ_XO_TOUCH_ST, th[i], i[0] ? 5'h07 : 5'h00), 1'b0, at[i], x, st);
      cmp(n_ack - n0, 1);
      cmp(last_cmd, dctz_pkg::DCTZ_CMD_TOUCH);
      cmp(last_addr, ea & ~64'h1f);
      cmp(last_hint, xh[i]);
      cmp(st[5:3], 3'h0);
      rd(`DCTZ_OFF_EA_LO, lo);
      rd(`DCTZ_OFF_EA_HI, hi);
      cmp({hi, lo}, ea);
    end
  endtask
  task automatic t_noop();
    logic [31:0] st;
    int          n0;
    n0 = n_ack;
    run(mk(`DCTZ_XO_TOUCH_ST, 5'h01, 5'h00), 1'b0, 5'h03, 64'h80, st);
    cmp(st[5:3], 3'h1);
    run(mk(`DCTZ_XO_TOUCH_ST, 5'h01, 5'h00), 1'b0, 5'h04, 64'h80, st);
    cmp(st[5:3], 3'h1);
    cmp(n_ack - n0, 0);
  endtask
  task automatic t_zero();
    logic [63:0] ea, x;
    logic [31:0] st;
    int          n0, w0;
    for (int i = 0; i < 3; i++) begin
      x = 64'h1234_5678 + 64'h100 * i;
      ea = (i == 1 ? BASE : 64'h0) + x;
      hit_en <= i == 0;
      slow <= i[0];
      n0 = n_ack;
      w0 = n_wb;
      run(mk(`DCTZ_XO_ZERO, 5'h00, i == 1 ? 5'h05 : 5'h00), i != 0, 5'h05, x, st);
      cmp(n_ack - n0, 2);
      cmp(last_cmd, i == 0 ? dctz_pkg::DCTZ_CMD_ZERO_CLR : dctz_pkg::DCTZ_CMD_ZERO_ALLOC);
      cmp(last_addr, ea & (i != 0 ? ~64'h3f : ~64'h1f));
      cmp(st[6:3], {i == 0, 3'h0});
      cmp(n_wb - w0, i == 1);
    end
    cmp(wb_idx, 5'h05);
    cmp(wb_data, BASE + 64'h1234_5778);
    n0 = n_ack;
    run(mk(`DCTZ_XO_ZERO, 5'h00, 5'h00), 1'b0, 5'h03, 64'h40, st);
    cmp(st[5], 1'b1);
    run(mk(`DCTZ_XO_ZERO, 5'h00, 5'h00) | 32'h1, 1'b0, 5'h04, 64'h40, st);
    cmp(st[4], 1'b1);
    run(mk(10'h000, 5'h00, 5'h00), 1'b0, 5'h04, 64'h40, st);
    cmp(st[4], 1'b1);
    cmp(n_ack - n0, 0);
  endtask
  task automatic t_stream();
    logic [63:0] cw[4] = '{64'h8001_5283, 64'h4001_ff85, 64'h6001_ff89, 64'h0c};
    logic [31:0] st, sr;
    int          n0, o0, a0;
    for (int i = 0; i < 4; i++) begin
      n0 = n_ack;
      o0 = n_one;
      a0 = n_all;
      run(mk(`DCTZ_XO_TOUCH_ST, i == 3 ? `DCTZ_HINT_DESC : `DCTZ_HINT_CTRL, 5'h00),
          1'b0, 5'h02, cw[i], st);
      rd(`DCTZ_OFF_STREAM, sr);
      cmp(n_ack - n0, 0);
      cmp({stream_id, sr[3:0]}, {2{cw[i][3:0]}});
      cmp(n_one - o0, i == 1);
      cmp(n_all - a0, i == 2);
      if (i < 3) cmp(sr[14:4], {1'b1, 10'h2a5});
    end
    cmp(sr[15], 1'b1);
  endtask
  task automatic t_apb();
    logic [31:0] q;
    logic        e;
    apb(1'b1, 8'h40, 32'h1, q, e);
    cmp(e, 1'b1);
    apb(1'b0, 8'h3c, 32'h0, q, e);
    cmp({e, q}, {1'b1, 32'h0});
    wr(`DCTZ_OFF_INSN, 32'h1234_5678);
    rd(`DCTZ_OFF_INSN, q);
    cmp(q, 32'h1234_5678);
  endtask
  // Guard against a hung handshake
  initial begin
    #400000;
    fails++;
    end_sim();
  end
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, hit_en, slow} = 6'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_apb();
    t_touch();
    t_noop();
    t_zero();
    t_stream();
    end_sim();
  end
endmodule
